// *** verilog/hsi_pkg.sv ***
// Constants and types for the halt and subtract instruction executer.
// Assumes a 14-bit instruction word delivered one per instruction cycle.
// Function
// - Power-down clears watchdog counter and prescaler
// - Power-down clears halt, sets expiry status
// - Decode power-down opcode; one cycle; halt oscillator
// - Literal minus accumulator; updates carry, half-byte, zero
// - Literal subtract always writes the accumulator
// - Register minus accumulator; updates carry, half-byte, zero
// - Destination bit selects accumulator or register
package hsi_pkg;
	localparam int HSI_IW = 14;
	localparam logic [13:0] HSI_OP_HALT = 14'h0063;
	localparam logic [5:0] HSI_OP_SUBL_MASK = 6'h3E;
	localparam logic [5:0] HSI_OP_SUBL = 6'h3C;
	localparam logic [5:0] HSI_OP_SUBR = 6'h02;
	localparam int HSI_DEST_BIT = 7;
	localparam logic [7:0] HSI_ACC_RESET = 8'h00;
	localparam logic [7:0] HSI_WATCHDOG_CLEAR = 8'h00;
	localparam logic HSI_FLAG_RESET = 1'b0;
	localparam logic HSI_STATUS_RESET = 1'b1;

	typedef enum logic [2:0] {
		HSI_NONE = 3'b001,
		HSI_HALT = 3'b010,
		HSI_SUB = 3'b100
	} hsi_kind_t;
endpackage : hsi_pkg

// *** verilog/hsi_alu_if.sv ***
// Operand and result bundle between the executer and its subtractor.
// Assumes both ends share one clock domain.
`timescale 1ns/10ps
interface hsi_alu_if;
	logic [7:0] minuend;
	logic [7:0] subtrahend;
	logic [7:0] result;
	logic carry;
	logic half_byte_overflow;
	logic zero;
	modport master (output minuend, output subtrahend, input result, input carry, input half_byte_overflow, input zero);
	modport slave (input minuend, input subtrahend, output result, output carry, output half_byte_overflow, output zero);
endinterface : hsi_alu_if

// *** verilog/hsi_sub.sv ***
// Combinational 8-bit subtractor producing flags.
// Assumes operands are stable during the cycle.
`timescale 1ns/10ps
module hsi_sub (
	hsi_alu_if.slave alu
);
	logic [8:0] full;
	logic [4:0] low;

	// Two's complement: add inverted subtrahend plus one; carry out means no borrow
	assign full = {1'b0, alu.minuend} + {1'b0, ~alu.subtrahend} + 9'h001;
	assign low = {1'b0, alu.minuend[3:0]} + {1'b0, ~alu.subtrahend[3:0]} + 5'h01;
	assign alu.result = full[7:0];
	assign alu.carry = full[8];
	assign alu.half_byte_overflow = low[4];
	assign alu.zero = (full[7:0] == 8'h00);
endmodule : hsi_sub

// *** verilog/hsi_exec.sv ***
// Executes power-down and the two subtract instructions.
// Assumes the datapath supplies the addressed register value in the same cycle
// and takes the file write strobe; other opcodes are ignored here.
// Assumes the wake-up logic outside releases the stopped oscillator through reset.
`timescale 1ns/10ps
module hsi_exec
	import hsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic instr_valid,
	input wire logic [HSI_IW-1:0] instr,
	input wire logic [7:0] file_rdata,
	output logic [6:0] file_addr,
	output logic [7:0] file_wdata,
	output logic file_we,
	output logic [7:0] acc_q,
	output logic carry_q,
	output logic half_byte_overflow_q,
	output logic zero_q,
	output logic expiry_status_q,
	output logic halt_status_q,
	output logic watchdog_clear,
	output logic osc_halt_q
);
	hsi_alu_if alu ();
	hsi_kind_t kind;
	logic is_subl;
	logic is_subr;
	logic go;

	// Decoders are shared by the datapath and by the checks below
	function automatic logic hsi_is_lit_sub(input logic [HSI_IW-1:0] word);
		return (word[13:8] & HSI_OP_SUBL_MASK) == HSI_OP_SUBL;
	endfunction : hsi_is_lit_sub

	function automatic logic hsi_is_reg_sub(input logic [HSI_IW-1:0] word);
		return word[13:8] == HSI_OP_SUBR;
	endfunction : hsi_is_reg_sub

	function automatic logic hsi_is_halt(input logic [HSI_IW-1:0] word);
		return word == HSI_OP_HALT;
	endfunction : hsi_is_halt

	// The literal form has no destination bit; its bit 7 is literal data
	function automatic logic hsi_to_acc(input logic [HSI_IW-1:0] word);
		return hsi_is_lit_sub(word) || !word[HSI_DEST_BIT];
	endfunction : hsi_to_acc

	hsi_sub u_sub (
		.alu(alu)
	);

	assign go = ce && instr_valid && !osc_halt_q;
	assign is_subl = hsi_is_lit_sub(instr);
	assign is_subr = hsi_is_reg_sub(instr);

	always_comb begin
		kind = HSI_NONE;
		if (hsi_is_halt(instr)) begin
			kind = HSI_HALT;
		end else if (is_subl || is_subr) begin
			kind = HSI_SUB;
		end
	end

	// Literal operand only for the literal form, register value otherwise
	assign alu.minuend = is_subl ? instr[7:0] : file_rdata;
	assign alu.subtrahend = acc_q;
	assign file_addr = instr[6:0];
	// Write-back is combinational so the datapath commits in this same cycle
	assign file_we = go && is_subr && instr[HSI_DEST_BIT];
	assign file_wdata = alu.result;
	assign watchdog_clear = go && (kind == HSI_HALT);

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= HSI_ACC_RESET;
		end else if (go && kind == HSI_SUB) begin
			// A register destination leaves the accumulator untouched
			if (hsi_to_acc(instr)) begin
				acc_q <= alu.result;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			carry_q <= HSI_FLAG_RESET;
			half_byte_overflow_q <= HSI_FLAG_RESET;
			zero_q <= HSI_FLAG_RESET;
		end else if (go && kind == HSI_SUB) begin
			carry_q <= alu.carry;
			half_byte_overflow_q <= alu.half_byte_overflow;
			zero_q <= alu.zero;
		end
	end

	// Status bits are active low in meaning; reset shows no timeout and no halt
	always_ff @(posedge clk) begin
		if (rst) begin
			expiry_status_q <= HSI_STATUS_RESET;
			halt_status_q <= HSI_STATUS_RESET;
			osc_halt_q <= 1'b0;
		end else if (go && kind == HSI_HALT) begin
			expiry_status_q <= 1'b1;
			halt_status_q <= 1'b0;
			osc_halt_q <= 1'b1;
		end
	end

	// Copies of the operands one cycle back, so the checks below can rebuild
	// the expected result from the inputs rather than from the subtractor
	logic [7:0] acc_prev;
	logic [7:0] instr_prev_lit;
	logic [7:0] rdata_prev;
	logic [7:0] min_prev;

	always_ff @(posedge clk) begin
		acc_prev <= acc_q;
		instr_prev_lit <= instr[7:0];
		rdata_prev <= file_rdata;
		min_prev <= alu.minuend;
	end

	// Power-down leaves the status pair in its sleeping state and stops the oscillator
	halt_flags_a: assert property (@(posedge clk) disable iff (rst)
		watchdog_clear |=> !halt_status_q && expiry_status_q && osc_halt_q)
		else $error("halt flags wrong");

	// Only the one exact word may clear the watchdog
	halt_decode_a: assert property (@(posedge clk) disable iff (rst)
		watchdog_clear |-> instr == HSI_OP_HALT)
		else $error("bad halt decode");

	// Every accepted power-down word must pulse the clear
	wd_clear_a: assert property (@(posedge clk) disable iff (rst)
		(ce && instr_valid && !osc_halt_q && instr == HSI_OP_HALT) |-> watchdog_clear)
		else $error("no watchdog clear");

	// Power-down touches no arithmetic flag and no accumulator bit
	halt_arith_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_HALT) |=> $stable(acc_q) && $stable(carry_q)
		&& $stable(half_byte_overflow_q) && $stable(zero_q))
		else $error("power-down changed arithmetic state");

	// Once stopped the core stays stopped until reset
	halt_hold_a: assert property (@(posedge clk) disable iff (rst)
		osc_halt_q |=> osc_halt_q)
		else $error("oscillator restarted");

	// A stopped core issues no strobes at all
	halted_quiet_a: assert property (@(posedge clk) disable iff (rst)
		osc_halt_q |-> !file_we && !watchdog_clear)
		else $error("strobe while halted");

	// Literal minus accumulator lands in the accumulator one edge later
	subl_value_a: assert property (@(posedge clk) disable iff (rst)
		(go && is_subl) |=> acc_q == 8'(instr_prev_lit - acc_prev))
		else $error("literal sub value");

	// The literal form never reaches the register file
	subl_nowrite_a: assert property (@(posedge clk) disable iff (rst)
		(go && is_subl) |-> !file_we)
		else $error("literal sub wrote file");

	// Register destination: strobe and value now, accumulator kept after
	subr_dest_a: assert property (@(posedge clk) disable iff (rst)
		(go && is_subr && instr[HSI_DEST_BIT])
		|-> file_we && file_wdata == 8'(file_rdata - acc_q) ##1 acc_q == acc_prev)
		else $error("register dest wrong");

	// Accumulator destination: register value minus accumulator
	subr_acc_a: assert property (@(posedge clk) disable iff (rst)
		(go && is_subr && !instr[HSI_DEST_BIT]) |=> acc_q == 8'(rdata_prev - acc_prev))
		else $error("acc dest wrong");

	// Carry means no borrow, so it follows an unsigned compare of the operands
	carry_borrow_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_SUB) |=> carry_q == (min_prev >= acc_prev))
		else $error("carry wrong");

	// The low nibble carries out exactly when it does not borrow
	half_byte_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_SUB) |=> half_byte_overflow_q == (min_prev[3:0] >= acc_prev[3:0]))
		else $error("half-byte flag wrong");

	// Zero result exactly when both operands were equal
	zero_flag_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_SUB) |=> zero_q == (min_prev == acc_prev))
		else $error("zero flag wrong");

	// Subtraction leaves the power status pair alone
	sub_status_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_SUB) |=> $stable(expiry_status_q) && $stable(halt_status_q))
		else $error("sub changed status");

	// A low enable freezes every register, even with a valid word present
	ce_freeze_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(acc_q) && $stable(carry_q) && $stable(half_byte_overflow_q)
		&& $stable(zero_q) && $stable(expiry_status_q) && $stable(halt_status_q) && $stable(osc_halt_q))
		else $error("state moved with enable low");

	// Strobes are only ever issued for an accepted word
	idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
		!go |-> !file_we && !watchdog_clear)
		else $error("strobe without accepted word");

	// Words outside the three opcodes pass through without effect
	foreign_op_a: assert property (@(posedge clk) disable iff (rst)
		(go && kind == HSI_NONE) |=> $stable(acc_q) && $stable(carry_q) && $stable(half_byte_overflow_q)
		&& $stable(zero_q) && $stable(expiry_status_q) && $stable(halt_status_q))
		else $error("foreign opcode changed state");

	// Main scenarios the bench is expected to reach
	halt_seen_c: cover property (@(posedge clk) disable iff (rst) watchdog_clear);
	subl_seen_c: cover property (@(posedge clk) disable iff (rst) go && is_subl);
	subr_file_c: cover property (@(posedge clk) disable iff (rst) file_we);
	borrow_seen_c: cover property (@(posedge clk) disable iff (rst) go && kind == HSI_SUB && !alu.carry);
	freeze_seen_c: cover property (@(posedge clk) disable iff (rst) !ce && instr_valid);
endmodule : hsi_exec

// *** testbench/tb_halt_and_subtract_instructions.sv ***
// Bench for the halt and subtract executer.
// Assumes hsi_pkg, hsi_alu_if, hsi_sub and hsi_exec are compiled first.
`timescale 1ns/10ps
module tb_halt_and_subtract_instructions;
	import hsi_pkg::*;
	typedef struct {logic [13:0] i; logic [7:0] r, a, w; logic [3:0] f;} hsi_row_t;
	logic clk = 0, rst = 1, ce = 1, iv = 0;
	logic [13:0] instr = '0;
	logic [7:0] rd = '0, wd, acc;
	logic [6:0] fa;
	logic we, c, dc, z, ex, hs, wc, oh;
	int miscompares = 0, n_checks = 0, cyc = 0;
	// Flags are {carry, half_byte_overflow, zero, file_we}
	hsi_row_t rows[8] = '{'{14'h3C02, 8'h00, 8'h02, 8'h00, 4'hC}, '{14'h3C03, 8'h00, 8'h01, 8'h00, 4'hC},
		'{14'h3D02, 8'h00, 8'h01, 8'h00, 4'hC}, '{14'h3C00, 8'h00, 8'hFF, 8'h00, 4'h0},
		'{14'h0285, 8'h01, 8'hFF, 8'h02, 4'h1}, '{14'h0205, 8'hFF, 8'h00, 8'h00, 4'hE},
		'{14'h3C01, 8'h00, 8'h01, 8'h00, 4'hC}, '{14'h3C10, 8'h00, 8'h0F, 8'h00, 4'h8}};
	always #2 clk = ~clk;
	hsi_exec dut (.clk(clk), .rst(rst), .ce(ce), .instr_valid(iv), .instr(instr), .file_rdata(rd),
		.file_addr(fa), .file_wdata(wd), .file_we(we), .acc_q(acc), .carry_q(c),
		.half_byte_overflow_q(dc), .zero_q(z), .expiry_status_q(ex), .halt_status_q(hs),
		.watchdog_clear(wc), .osc_halt_q(oh));
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task step(input logic [13:0] i, input logic [7:0] r);
		@(negedge clk);
		instr = i;
		rd = r;
		iv = 1;
		#1;
	endtask : step
	task tick;
		@(posedge clk);
		#1;
	endtask : tick
	task finish_test;
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			finish_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 0;
		chk(acc, 8'h00);
		chk({2'h0, c, dc, z, ex, hs, oh}, 8'h06);
		foreach (rows[k]) begin
			step(rows[k].i, rows[k].r);
			chk({fa, we}, {rows[k].i[6:0], rows[k].f[0]});
			if (rows[k].f[0]) chk(wd, rows[k].w);
			tick;
			chk(acc, rows[k].a);
			chk({5'h00, c, dc, z}, {5'h00, rows[k].f[3:1]});
			$display("Row %0d done", k);
		end
		// Frozen clock enable, idle slot and a foreign opcode must change nothing
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			instr = k == 2 ? 14'h0100 : 14'h0285;
			rd = 8'h00;
			ce = k != 0;
			iv = k != 1;
			#1 chk({6'h00, wc, we}, 8'h00);
			tick;
			chk(acc, 8'h0F);
			chk({5'h00, c, dc, z}, 8'h04);
		end
		$display("Ignore test done");
		step(HSI_OP_HALT, 8'h00);
		chk({7'h00, wc}, 8'h01);
		tick;
		chk({2'h0, ex, hs, oh, c, dc, z}, 8'h2C);
		step(14'h3C55, 8'h00);
		chk({6'h00, wc, we}, 8'h00);
		tick;
		chk(acc, 8'h0F);
		$display("Halt test done");
		@(negedge clk) rst = 1;
		iv = 0;
		@(negedge clk) rst = 0;
		chk({2'h0, c, dc, z, ex, hs, oh}, 8'h06);
		chk(acc, 8'h00);
		step(14'h3C05, 8'h00);
		chk({6'h00, wc, we}, 8'h00);
		tick;
		chk(acc, 8'h05);
		chk({5'h00, c, dc, z}, 8'h06);
		$display("Reset test done");
		finish_test;
	end
endmodule : tb_halt_and_subtract_instructions
